// *** logic/lsu_consts.svh ***
/*
 * Constants of the load/store access unit: address space identifier
 * bounds, immediate width, address range and reset values.
 * Assumes inclusion by the package and the unit, by its bare name.
 */
`ifndef LSU_CONSTS_SVH
`define LSU_CONSTS_SVH

// identifier bounds: up to priv max needs privileged mode, up to hyper max
// needs hyperprivileged mode, anything above is open to every mode
`define LSU_ASI_PRIV_MAX   8'h2f
`define LSU_ASI_HYPER_MAX  8'h7f
// identifier attached to plain (non-alternate) data accesses
`define LSU_ASI_DEFAULT    8'h80

// field widths
`define LSU_IMM_W          13
`define LSU_XLEN           64
`define LSU_QLEN           128
`define LSU_VA_BITS        64

// reset values
`define LSU_RST_ADDR       64'h0000_0000_0000_0000
`define LSU_RST_DATA       128'h0
`define LSU_RST_ASI        8'h00

`endif

// *** logic/lsu_pkg.sv ***
/*
 * Types of the load/store access unit: instruction request, memory
 * request, privilege modes, trap codes and unit states.
 * Assumes lsu_consts.svh is on the include path.
 */
`include "lsu_consts.svh"

package lsu_pkg;

	typedef enum logic [2:0] {
		OPC_OTHER    = 3'h0,
		OPC_LOAD     = 3'h1,
		OPC_STORE    = 3'h2,
		OPC_ATOMIC   = 3'h3,
		OPC_PREFETCH = 3'h4,
		OPC_FLUSH    = 3'h5
	} op_class_t;

	// transfer size; byte count is 1 << size
	typedef enum logic [2:0] {
		SZ_BYTE  = 3'h0,
		SZ_HALF  = 3'h1,
		SZ_WORD  = 3'h2,
		SZ_DWORD = 3'h3,
		SZ_QUAD  = 3'h4
	} size_t;

	typedef enum logic [2:0] {
		AT_NONE      = 3'h0,
		AT_CAS_WORD  = 3'h1,
		AT_CAS_DWORD = 3'h2,
		AT_BYTE_SET  = 3'h3,
		AT_TWIN_LOAD = 3'h4
	} atomic_t;

	typedef enum logic [1:0] {
		MODE_USER  = 2'h0,
		MODE_PRIV  = 2'h1,
		MODE_HYPER = 2'h2
	} priv_mode_t;

	typedef enum logic [2:0] {
		TRAP_NONE        = 3'h0,
		TRAP_FLOAT_OFF   = 3'h1,
		TRAP_EMULATE     = 3'h2,
		TRAP_PRIV_ACTION = 3'h3,
		TRAP_ALIGN       = 3'h4,
		TRAP_RANGE       = 3'h5
	} trap_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT  = 3'b100
	} lsu_state_t;

	typedef struct packed {
		op_class_t             op_class;
		size_t                 size;
		atomic_t               atomic;
		logic                  is_float;
		logic                  sign_ext;
		logic                  alt_space;
		logic                  needs_priv;
		logic                  use_imm;
		logic [7:0]            address_space_id;
		logic [`LSU_IMM_W-1:0] imm;
		logic [`LSU_XLEN-1:0]  rs1;
		logic [`LSU_XLEN-1:0]  rs2;
		logic [`LSU_XLEN-1:0]  cmp_data;
		logic [`LSU_QLEN-1:0]  store_data;
	} issue_req_t;

	typedef struct packed {
		op_class_t             op_class;
		atomic_t               atomic;
		size_t                 size;
		logic                  little;
		logic [2:0]            reg_count;
		logic [7:0]            address_space_id;
		logic [`LSU_XLEN-1:0]  addr;
		logic [`LSU_XLEN-1:0]  cmp_data;
		logic [`LSU_QLEN-1:0]  data;
	} mem_req_t;

endpackage

// *** logic/load_store_access_unit.sv ***
/*
 * Load/store access unit: forms addresses, checks privilege, alignment
 * and address range, orders bytes, issues one memory request at a time
 * and extends loaded data.
 * Assumes pipeline and memory run on sys_clk; memory answers each load
 * or atomic with exactly one rsp_valid pulse, in order.
 */
// What this block does
// - only load, store, atomic and prefetch operations reach memory
// - address is rs1 plus rs2, or rs1 plus sign-extended 13-bit immediate
// - every access carries an 8-bit identifier; alternate forms supply it
// - identifiers to 2f need privileged, to 7f hyperprivileged, above open
// - an operation needing more privilege than the current mode traps
// - except for prefetch, address must align to the datum size, else an alignment trap
// - big-endian by default: address selects the most significant byte
// - instruction fetches are always big-endian
// - little-endian data: address selects the least significant byte
// - integer transfers of byte, halfword, word and extended word
// - byte, half and word loads sign- or zero-extend to 64 bits
// - operand is one or two integer, or one, two, four float registers
// - quad float load is not executed; it traps for emulation
// - short virtual addresses accept only the lowest and highest halves
// - compare-swap word and dword and byte load-and-set, with alt forms
// - twin load returns 128 bits as one indivisible read
// - with the float unit off, float accesses take the float-off trap
// - flush discards possibly stale fetched instructions
`include "lsu_consts.svh"

module load_store_access_unit #(
	parameter int VA_BITS = `LSU_VA_BITS
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 nrst,
	// instruction side
	input  wire logic                 req_valid,
	output logic                      req_ready,
	input  wire lsu_pkg::issue_req_t  req,
	input  wire lsu_pkg::priv_mode_t  mode,
	input  wire logic                 float_en,
	input  wire logic                 data_little,
	// trap report
	output logic                      trap_valid,
	output lsu_pkg::trap_t            trap_code,
	// fetch side
	output logic                      fetch_flush,
	output logic                      fetch_little,
	// memory request
	output logic                      mem_valid,
	input  wire logic                 mem_ready,
	output lsu_pkg::mem_req_t         mem_req,
	// memory answer and load result
	input  wire logic                 rsp_valid,
	input  wire logic [127:0]         rsp_data,
	output logic                      ld_valid,
	output logic [127:0]              ld_data,
	output logic [2:0]                ld_reg_count
);
	import lsu_pkg::*;

	// elaboration check: the range test needs at least one top bit
	if (VA_BITS < 2 || VA_BITS > 64) begin : g_va_check
		$error("VA_BITS must lie between 2 and 64");
	end

	// reverse bytes inside the datum for little-endian data
	function automatic logic [127:0] order_bytes(input logic [127:0] d,
			input logic [4:0] n, input logic little);
		logic [127:0] o;
		o = d;
		if (little) begin
			for (int i = 0; i < 16; i++) begin
				if (i < int'(n))
					o[8*i +: 8] = d[8*(int'(n)-1-i) +: 8];
			end
		end
		return o;
	endfunction

	lsu_state_t            state_reg, state_next;
	mem_req_t              mem_req_reg;
	logic                  trap_valid_reg, fetch_flush_reg, ld_valid_reg;
	trap_t                 trap_code_reg;
	logic [127:0]          ld_data_reg;
	logic [2:0]            ld_count_reg;
	logic                  ld_sign_reg;

	// effective address and identifier
	wire logic [63:0] imm_sext = {{(64-`LSU_IMM_W){req.imm[`LSU_IMM_W-1]}},
		req.imm};
	wire logic [63:0] eff_addr = req.rs1 + (req.use_imm ? imm_sext
		: req.rs2);
	wire logic [7:0]  asi_sel = req.alt_space ? req.address_space_id
		: `LSU_ASI_DEFAULT;

	// atomics fix their own size; other requests use the given size
	wire logic   is_atomic = req.op_class == OPC_ATOMIC;
	wire size_t  eff_size  = !is_atomic ? req.size
		: req.atomic == AT_CAS_WORD  ? SZ_WORD
		: req.atomic == AT_CAS_DWORD ? SZ_DWORD
		: req.atomic == AT_BYTE_SET  ? SZ_BYTE : SZ_QUAD;
	wire logic [4:0] n_bytes = 5'(5'h1 << eff_size);
	wire logic is_mem = req.op_class inside {OPC_LOAD, OPC_STORE,
		OPC_ATOMIC, OPC_PREFETCH};

	// checks, all evaluated before anything is issued
	wire logic asi_ok = asi_sel > `LSU_ASI_HYPER_MAX
		|| (asi_sel > `LSU_ASI_PRIV_MAX && mode == MODE_HYPER)
		|| (asi_sel <= `LSU_ASI_PRIV_MAX && mode != MODE_USER);
	wire logic priv_ok = !req.needs_priv || mode != MODE_USER;
	wire logic align_ok = (eff_addr[3:0] & 4'(n_bytes - 5'h1)) == 4'h0;
	wire logic [64-VA_BITS:0] top_bits = eff_addr[63:VA_BITS-1];
	wire logic range_ok = &top_bits || ~|top_bits;
	wire logic quad_fload = req.is_float && req.op_class == OPC_LOAD
		&& eff_size == SZ_QUAD;

	// priority: float off, emulation, privilege, alignment, range;
	// float and privilege checks cover every class, not only memory
	// operations, so a non-memory instruction cannot dodge its trap
	wire trap_t trap_sel = req.is_float && !float_en ? TRAP_FLOAT_OFF
		: quad_fload ? TRAP_EMULATE
		: !priv_ok || (is_mem && req.alt_space && !asi_ok)
			? TRAP_PRIV_ACTION
		: is_mem && !align_ok && req.op_class != OPC_PREFETCH
			? TRAP_ALIGN
		: is_mem && !range_ok ? TRAP_RANGE : TRAP_NONE;

	// operand register count: integer 1 or 2, float 1, 2 or 4 words
	wire logic [2:0] reg_cnt = req.is_float
		? (eff_size == SZ_QUAD ? 3'h4 : eff_size == SZ_DWORD ? 3'h2 : 3'h1)
		: (eff_size == SZ_QUAD ? 3'h2 : 3'h1);

	// fetch never sees the data byte order
	wire logic little_sel = data_little;
	wire logic accept = req_valid && state_reg == ST_IDLE;
	wire logic issue = accept && is_mem && trap_sel == TRAP_NONE;
	wire logic needs_rsp = mem_req_reg.op_class inside {OPC_LOAD,
		OPC_ATOMIC};

	// state sequencing: one request in flight keeps ordering simple
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:  if (issue) state_next = ST_ISSUE;
			ST_ISSUE: if (mem_ready)
				state_next = needs_rsp ? ST_WAIT : ST_IDLE;
			ST_WAIT:  if (rsp_valid) state_next = ST_IDLE;
			default:  state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// request register; loaded only when every check passed
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mem_req_reg <= '0;
		end else if (issue) begin
			mem_req_reg.op_class  <= req.op_class;
			mem_req_reg.atomic    <= is_atomic ? req.atomic : AT_NONE;
			mem_req_reg.size      <= eff_size;
			mem_req_reg.little    <= little_sel;
			mem_req_reg.reg_count <= reg_cnt;
			mem_req_reg.address_space_id       <= asi_sel;
			mem_req_reg.addr      <= eff_addr;
			mem_req_reg.cmp_data  <= req.cmp_data;
			mem_req_reg.data      <= order_bytes(req.store_data, n_bytes,
				little_sel);
		end
	end

	// trap and flush pulses; a flush touches no memory
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			trap_valid_reg  <= 1'b0;
			trap_code_reg   <= TRAP_NONE;
			fetch_flush_reg <= 1'b0;
		end else begin
			trap_valid_reg  <= accept && trap_sel != TRAP_NONE;
			trap_code_reg   <= accept ? trap_sel : TRAP_NONE;
			fetch_flush_reg <= accept && req.op_class == OPC_FLUSH
				&& trap_sel == TRAP_NONE;
		end
	end

	// load answer: reorder, then extend narrow integers
	wire logic [4:0]   rsp_n = 5'(5'h1 << mem_req_reg.size);
	wire logic [127:0] rsp_ord = order_bytes(rsp_data, rsp_n,
		mem_req_reg.little);
	wire logic         sx = ld_sign_reg && !mem_req_reg.reg_count[2];
	wire logic [127:0] rsp_ext =
		mem_req_reg.size == SZ_BYTE ? {64'h0, {56{sx & rsp_ord[7]}},
			rsp_ord[7:0]}
		: mem_req_reg.size == SZ_HALF ? {64'h0, {48{sx & rsp_ord[15]}},
			rsp_ord[15:0]}
		: mem_req_reg.size == SZ_WORD ? {64'h0, {32{sx & rsp_ord[31]}},
			rsp_ord[31:0]}
		: rsp_ord;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ld_valid_reg <= 1'b0;
			ld_data_reg  <= `LSU_RST_DATA;
			ld_count_reg <= 3'h0;
			ld_sign_reg  <= 1'b0;
		end else begin
			ld_valid_reg <= state_reg == ST_WAIT && rsp_valid;
			if (issue)
				ld_sign_reg <= req.sign_ext && !req.is_float
					&& !is_atomic;
			if (state_reg == ST_WAIT && rsp_valid) begin
				ld_data_reg  <= rsp_ext;
				ld_count_reg <= mem_req_reg.reg_count;
			end
		end
	end

	// outputs; no new request while one is in flight
	assign req_ready    = state_reg == ST_IDLE;
	assign mem_valid    = state_reg == ST_ISSUE;
	assign mem_req      = mem_req_reg;
	assign trap_valid   = trap_valid_reg;
	assign trap_code    = trap_code_reg;
	assign fetch_flush  = fetch_flush_reg;
	assign fetch_little = 1'b0;
	assign ld_valid     = ld_valid_reg;
	assign ld_data      = ld_data_reg;
	assign ld_reg_count = ld_count_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_only_mem_ops: assert property (mem_valid |-> mem_req.op_class inside
		{OPC_LOAD, OPC_STORE, OPC_ATOMIC, OPC_PREFETCH})
		else $error("non-memory class reached memory");
	a_imm_addr: assert property (issue && req.use_imm |=> mem_valid
		&& mem_req.addr == $past(req.rs1) + {{51{$past(req.imm[12])}},
		$past(req.imm)})
		else $error("immediate address form wrong");
	a_plain_asi: assert property (issue && !req.alt_space |=>
		mem_req.address_space_id == `LSU_ASI_DEFAULT)
		else $error("plain access lost its default identifier");
	a_asi_user: assert property (accept && is_mem && req.alt_space
		&& !req.is_float && req.address_space_id <= `LSU_ASI_HYPER_MAX
		&& mode == MODE_USER |=> trap_valid
		&& trap_code == TRAP_PRIV_ACTION && !mem_valid)
		else $error("low identifier not refused in user mode");
	a_priv_op: assert property (accept && req.needs_priv && !req.is_float
		&& mode == MODE_USER |=> trap_valid ##1 !mem_valid)
		else $error("privileged operation not trapped");
	a_misalign: assert property (accept && req.op_class == OPC_LOAD
		&& !req.is_float && req.size == SZ_WORD && eff_addr[1:0] != 2'h0
		&& priv_ok && !req.alt_space
		|=> trap_code == TRAP_ALIGN && !mem_valid)
		else $error("misaligned word load issued");
	a_half_little: assert property (issue && req.op_class == OPC_STORE
		&& eff_size == SZ_HALF && little_sel |=> mem_req.data[15:0] ==
		{$past(req.store_data[7:0]), $past(req.store_data[15:8])})
		else $error("little-endian halfword not swapped");
	a_half_big: assert property (issue && req.op_class == OPC_STORE
		&& !little_sel |=> mem_req.data == $past(req.store_data))
		else $error("big-endian data altered");
	a_fetch_big: assert property (!fetch_little)
		else $error("fetch byte order changed");
	a_byte_sext: assert property (ld_valid && mem_req.size == SZ_BYTE
		&& $past(ld_sign_reg) |-> ld_data[63:8] == {56{ld_data[7]}})
		else $error("byte load not sign extended");
	a_quad_emul: assert property (accept && quad_fload && float_en |=>
		trap_code == TRAP_EMULATE ##1 !mem_valid)
		else $error("quad float load executed");
	a_float_off: assert property (accept && req.is_float && !float_en
		|=> trap_code == TRAP_FLOAT_OFF ##1 state_reg == ST_IDLE)
		else $error("float access ran with float unit off");
	a_twin_read: assert property (mem_valid && mem_req.atomic ==
		AT_TWIN_LOAD |-> mem_req.size == SZ_QUAD)
		else $error("twin load split");
	a_flush_pulse: assert property (accept && req.op_class == OPC_FLUSH
		&& trap_sel == TRAP_NONE
		##1 !(accept && req.op_class == OPC_FLUSH)
		|-> fetch_flush && !mem_valid ##1 !fetch_flush)
		else $error("flush pulse wrong");
	a_fault_quiet: assert property (trap_valid |-> state_reg == ST_IDLE
		&& !ld_valid)
		else $error("faulting access had effects");

	c_load_done:  cover property (issue && req.op_class == OPC_LOAD
		##[1:20] ld_valid);
	c_store_done: cover property (mem_valid && mem_ready
		&& mem_req.op_class == OPC_STORE);
	c_cas_alt:    cover property (mem_valid && mem_req.atomic ==
		AT_CAS_DWORD && mem_req.address_space_id != `LSU_ASI_DEFAULT);
	c_trap_align: cover property (trap_valid && trap_code == TRAP_ALIGN);
	c_half_le:    cover property (issue && req.op_class == OPC_STORE
		&& eff_size == SZ_HALF && little_sel);

endmodule

// *** verification/mem_partner.sv ***
/*
 * Behavioural cache and memory side facing the load/store access unit.
 * Assumes the unit's memory handshake on sys_clk and the lsu_pkg types.
 */
module mem_partner (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	// request from the unit
	input  wire logic              mem_valid,
	output logic                   mem_ready,
	input  wire lsu_pkg::mem_req_t mem_req,
	// answer and bench view
	input  wire logic [3:0]        delay,
	output logic                   rsp_valid,
	output logic [127:0]           rsp_data,
	output int                     taken
);
	timeunit 1ns;
	timeprecision 100ps;
	import lsu_pkg::*;

	localparam logic [127:0] PAT = 128'h0f0e0d0c0b0a0908_8182838485868788;

	logic [3:0]  wait_cnt_reg;
	logic        pend_reg;
	logic [31:0] cyc_reg;

	// idle data keeps moving so a stale read never passes for an answer
	assign rsp_data = rsp_valid ? PAT : {4{cyc_reg}};

	// one outstanding request; answer waits delay cycles, ready too except for the request after an answer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mem_ready    <= 1'b0;
			rsp_valid    <= 1'b0;
			pend_reg     <= 1'b0;
			wait_cnt_reg <= 4'h0;
			cyc_reg      <= 32'h0;
			taken        <= 0;
		end else begin
			mem_ready <= 1'b0;
			rsp_valid <= 1'b0;
			cyc_reg   <= cyc_reg + 32'h1;
			if (mem_valid && mem_ready) begin
				taken        <= taken + 1;
				pend_reg     <= mem_req.op_class inside {OPC_LOAD, OPC_ATOMIC};
				wait_cnt_reg <= 4'h0;
			end else if ((mem_valid && !mem_ready) || pend_reg) begin
				if (wait_cnt_reg < delay)
					wait_cnt_reg <= wait_cnt_reg + 4'h1;
				else if (mem_valid)
					mem_ready <= 1'b1;
				else begin
					rsp_valid <= 1'b1;
					pend_reg  <= 1'b0;
				end
			end
		end
	end
endmodule

// *** verification/tb_top.sv ***
/*
 * Self-checking bench for the load/store access unit with a memory model.
 * Assumes a 48-bit virtual address build and a big-endian memory answer.
 */
`include "lsu_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import lsu_pkg::*;

	typedef struct packed {
		issue_req_t   q;
		priv_mode_t   m;
		logic         le;
		logic         fen;
		trap_t        tr;
		logic [63:0]  a;
		logic [127:0] d;
		logic [2:0]   n;
	} row_t;

	logic         sys_clk = 1'b0;
	logic         nrst, req_valid, req_ready, float_en, data_little;
	issue_req_t   req;
	priv_mode_t   mode;
	logic         trap_valid, fetch_flush, fetch_little, mem_valid;
	trap_t        trap_code;
	logic         mem_ready, rsp_valid, ld_valid;
	mem_req_t     mem_req;
	logic [127:0] rsp_data, ld_data;
	logic [2:0]   ld_reg_count;
	logic [3:0]   delay;
	int           taken;
	int           miscompares = 0;
	int           checks_done = 0;
	row_t         rows[$];

	load_store_access_unit #(.VA_BITS(48)) load_store_access_unit_inst (
		.sys_clk, .nrst, .req_valid, .req_ready, .req, .mode, .float_en,
		.data_little, .trap_valid, .trap_code, .fetch_flush, .fetch_little,
		.mem_valid, .mem_ready, .mem_req, .rsp_valid, .rsp_data, .ld_valid,
		.ld_data, .ld_reg_count);
	mem_partner mem_partner_inst (.sys_clk, .nrst, .mem_valid, .mem_ready,
		.mem_req, .delay, .rsp_valid, .rsp_data, .taken);

	// free-running 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// flags are is_float, sign_ext, alt_space, needs_priv, use_imm
	function automatic row_t r(op_class_t o, size_t z, atomic_t t,
		logic [4:0] f, logic [7:0] s, logic [12:0] i, logic [63:0] b,
		priv_mode_t m, logic [1:0] lf, trap_t tr, logic [63:0] a,
		logic [127:0] d, logic [2:0] n);
		row_t w;
		w = '0;
		w.q.op_class = o;
		w.q.size = z;
		w.q.atomic = t;
		{w.q.is_float, w.q.sign_ext, w.q.alt_space, w.q.needs_priv,
			w.q.use_imm} = f;
		w.q.address_space_id = s;
		w.q.imm = i;
		w.q.rs1 = b;
		w.q.rs2 = 64'h10;
		w.q.store_data = 128'h0102030405060708;
		w.q.cmp_data = 64'h0123_4567_89ab_cdef;
		w.m = m;
		{w.le, w.fen} = lf;
		w.tr = tr;
		w.a = a;
		w.d = d;
		w.n = n;
		return w;
	endfunction

	// one request end to end; faults must leave memory untouched
	task automatic go(input row_t w);
		logic        iss;
		logic        rsp;
		logic [63:0] mk;
		int          t0;
		iss = w.tr == TRAP_NONE && w.q.op_class inside
			{OPC_LOAD, OPC_STORE, OPC_ATOMIC, OPC_PREFETCH};
		rsp = iss && w.q.op_class inside {OPC_LOAD, OPC_ATOMIC};
		mk = w.q.size == SZ_DWORD ? '1 : (64'h1 << (8 << w.q.size)) - 64'h1;
		t0 = taken;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req = w.q;
		mode = w.m;
		data_little = w.le;
		float_en = w.fen;
		@(negedge sys_clk);
		req_valid = 1'b0;
		chk(trap_code, w.tr);
		chk(trap_valid, w.tr != TRAP_NONE);
		chk(mem_valid, iss);
		chk(fetch_flush, w.q.op_class == OPC_FLUSH);
		chk(fetch_little, 1'b0);
		if (iss) begin
			chk(mem_req.addr, w.a);
			chk(mem_req.address_space_id, w.q.alt_space ? w.q.address_space_id : `LSU_ASI_DEFAULT);
			chk(mem_req.size, w.q.size);
			chk(mem_req.atomic, w.q.atomic);
			chk(mem_req.op_class, w.q.op_class);
			chk(mem_req.cmp_data, w.q.cmp_data);
			chk(mem_req.little, w.le);
		end
		if (iss && w.q.op_class != OPC_PREFETCH)
			chk(mem_req.reg_count, w.n);
		if (iss && w.q.op_class == OPC_STORE)
			chk(mem_req.data[63:0] & mk, w.d[63:0]);
		for (int i = 0; i < 80 && rsp && ld_valid !== 1'b1; i++)
			@(negedge sys_clk);
		if (rsp) begin
			chk(ld_valid, 1'b1);
			chk(w.q.size == SZ_QUAD ? ld_data : {64'h0, ld_data[63:0]}, w.d);
			chk(ld_reg_count, w.n);
		end
		for (int i = 0; i < 80 && req_ready !== 1'b1; i++)
			@(negedge sys_clk);
		chk(req_ready, 1'b1);
		@(negedge sys_clk);
		chk(trap_valid, 1'b0);
		chk(taken - t0, iss);
	endtask

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#100000;
		miscompares++;
		summarize();
	end

	// main sequence
	initial begin
		nrst = 1'b0;
		req_valid = 1'b0;
		req = '0;
		mode = MODE_USER;
		float_en = 1'b1;
		data_little = 1'b0;
		delay = 4'h0;
		repeat (16) @(posedge sys_clk);
		chk(req_ready, 1'b1);
		chk(mem_valid, 1'b0);
		chk(trap_code, TRAP_NONE);
		@(negedge sys_clk);
		nrst = 1'b1;
		rows = '{
r(OPC_LOAD, SZ_BYTE, AT_NONE, 5'h09, 8'h00, 13'h1fff, 64'h1000, MODE_USER,
	2'h1, TRAP_NONE, 64'hfff, 128'hffff_ffff_ffff_ff88, 3'h1),
r(OPC_LOAD, SZ_HALF, AT_NONE, 5'h00, 8'h00, 13'h0, 64'h1000, MODE_USER,
	2'h3, TRAP_NONE, 64'h1010, 128'h8887, 3'h1),
r(OPC_LOAD, SZ_WORD, AT_NONE, 5'h09, 8'h00, 13'h8, 64'h1000, MODE_USER,
	2'h1, TRAP_NONE, 64'h1008, 128'hffff_ffff_8586_8788, 3'h1),
r(OPC_LOAD, SZ_DWORD, AT_NONE, 5'h01, 8'h00, 13'h0, 64'h2000, MODE_USER,
	2'h3, TRAP_NONE, 64'h2000, 128'h8887_8685_8483_8281, 3'h1),
r(OPC_STORE, SZ_DWORD, AT_NONE, 5'h01, 8'h00, 13'h8, 64'h2000, MODE_USER,
	2'h3, TRAP_NONE, 64'h2008, 128'h0807_0605_0403_0201, 3'h1),
r(OPC_STORE, SZ_HALF, AT_NONE, 5'h01, 8'h00, 13'h2, 64'h1000, MODE_USER,
	2'h3, TRAP_NONE, 64'h1002, 128'h0807, 3'h1),
r(OPC_STORE, SZ_WORD, AT_NONE, 5'h01, 8'h00, 13'h2, 64'h1000, MODE_USER,
	2'h1, TRAP_ALIGN, 0, 0, 0),
r(OPC_LOAD, SZ_BYTE, AT_NONE, 5'h05, 8'h2f, 13'h0, 64'h1000, MODE_USER,
	2'h1, TRAP_PRIV_ACTION, 0, 0, 0),
r(OPC_LOAD, SZ_BYTE, AT_NONE, 5'h05, 8'h2f, 13'h0, 64'h1000, MODE_PRIV,
	2'h1, TRAP_NONE, 64'h1000, 128'h88, 3'h1),
r(OPC_LOAD, SZ_BYTE, AT_NONE, 5'h05, 8'h30, 13'h0, 64'h1000, MODE_PRIV,
	2'h1, TRAP_PRIV_ACTION, 0, 0, 0),
r(OPC_LOAD, SZ_BYTE, AT_NONE, 5'h05, 8'h7f, 13'h0, 64'h1000, MODE_HYPER,
	2'h1, TRAP_NONE, 64'h1000, 128'h88, 3'h1),
r(OPC_STORE, SZ_BYTE, AT_NONE, 5'h05, 8'h80, 13'h5, 64'h1000, MODE_USER,
	2'h1, TRAP_NONE, 64'h1005, 128'h08, 3'h1),
r(OPC_STORE, SZ_WORD, AT_NONE, 5'h03, 8'h00, 13'h0, 64'h1000, MODE_USER,
	2'h1, TRAP_PRIV_ACTION, 0, 0, 0),
r(OPC_LOAD, SZ_QUAD, AT_NONE, 5'h11, 8'h00, 13'h0, 64'h1000, MODE_USER,
	2'h1, TRAP_EMULATE, 0, 0, 0),
r(OPC_LOAD, SZ_WORD, AT_NONE, 5'h11, 8'h00, 13'h0, 64'h1000, MODE_USER,
	2'h0, TRAP_FLOAT_OFF, 0, 0, 0),
r(OPC_LOAD, SZ_DWORD, AT_NONE, 5'h11, 8'h00, 13'h8, 64'h1000, MODE_USER,
	2'h1, TRAP_NONE, 64'h1008, 128'h8182_8384_8586_8788, 3'h2),
r(OPC_ATOMIC, SZ_WORD, AT_CAS_WORD, 5'h05, 8'h80, 13'h0, 64'h1000,
	MODE_USER, 2'h1, TRAP_NONE, 64'h1000, 128'h8586_8788, 3'h1),
r(OPC_ATOMIC, SZ_DWORD, AT_CAS_DWORD, 5'h05, 8'h81, 13'h8, 64'h1000,
	MODE_USER, 2'h1, TRAP_NONE, 64'h1008, 128'h8182_8384_8586_8788, 3'h1),
r(OPC_ATOMIC, SZ_BYTE, AT_BYTE_SET, 5'h05, 8'h82, 13'h3, 64'h1000,
	MODE_USER, 2'h1, TRAP_NONE, 64'h1003, 128'h88, 3'h1),
r(OPC_ATOMIC, SZ_QUAD, AT_TWIN_LOAD, 5'h05, 8'h83, 13'h10, 64'h1000,
	MODE_USER, 2'h1, TRAP_NONE, 64'h1010,
	128'h0f0e0d0c0b0a0908_8182838485868788, 3'h2),
r(OPC_PREFETCH, SZ_DWORD, AT_NONE, 5'h01, 8'h00, 13'h1, 64'h1000,
	MODE_USER, 2'h1, TRAP_NONE, 64'h1001, 0, 0),
r(OPC_OTHER, SZ_BYTE, AT_NONE, 5'h01, 8'h00, 13'h0, 64'h1000, MODE_USER,
	2'h1, TRAP_NONE, 0, 0, 0),
r(OPC_FLUSH, SZ_BYTE, AT_NONE, 5'h01, 8'h00, 13'h0, 64'h1000, MODE_USER,
	2'h1, TRAP_NONE, 0, 0, 0),
r(OPC_LOAD, SZ_BYTE, AT_NONE, 5'h01, 8'h00, 13'h0, 64'h0000_8000_0000_0000,
	MODE_USER, 2'h1, TRAP_RANGE, 0, 0, 0),
r(OPC_LOAD, SZ_BYTE, AT_NONE, 5'h01, 8'h00, 13'h0, 64'hffff_8000_0000_0000,
	MODE_USER, 2'h1, TRAP_NONE, 64'hffff_8000_0000_0000, 128'h88, 3'h1)};
		foreach (rows[k])
			go(rows[k]);
		// back-to-back faults: ready never drops, each traps in turn
		@(negedge sys_clk);
		mode = MODE_USER;
		req_valid = 1'b1;
		req = rows[6].q;
		@(negedge sys_clk);
		chk(trap_code, TRAP_ALIGN);
		req = rows[7].q;
		@(negedge sys_clk);
		req_valid = 1'b0;
		chk(trap_code, TRAP_PRIV_ACTION);
		// slow memory stalls both the handshake and the answer
		delay = 4'h6;
		// reset in mid-transfer: the stalled load is dropped cleanly
		@(negedge sys_clk);
		req_valid = 1'b1;
		req = rows[0].q;
		@(negedge sys_clk);
		req_valid = 1'b0;
		repeat (3) @(negedge sys_clk);
		nrst = 1'b0;
		@(negedge sys_clk);
		chk(req_ready, 1'b1);
		chk(mem_valid, 1'b0);
		chk(ld_valid, 1'b0);
		chk(trap_valid, 1'b0);
		chk(mem_req.addr, `LSU_RST_ADDR);
		nrst = 1'b1;
		go(rows[0]);
		go(rows[19]);
		summarize();
	end
endmodule
